/* File: verilog/aiu_audio_in.sv */
// audio input unit: serial receiver, link master/slave, oversampling clock
// Function
// - the port always receives serial data; master or slave of timing
// - after reset the port is slave and the bit clock pin is input; the code follows cfg.master, which reset does not touch
// - slave bit clock is asynchronous and is synchronised before use
// - master drives the bit clock at oversampling clock over a divisor
// - the bit clock never exceeds 22 MHz, driven or received; driven rate is not limited, fast edges only flagged
// - oversampling clock output programmable up to 40 MHz, fine step; osc_phase_inc is not limited, fast rates only asserted
// - serial data is sampled on rising or falling edge by edge select
// - slave word select is input, sampled on the data sampling edge
// - master drives word select, changing on the opposite edge
// - word select marks the boundaries of sample frames
// - sample rate is variable; no fixed bits-per-sample is assumed
`timescale 1ns/1ps
`default_nettype none
`include "aiu_regs.svh"

module aiu_audio_in #(
    parameter int SAMPLE_W = `AIU_SAMPLE_W,
    parameter int DIV_W    = `AIU_DIV_W,
    parameter int FRAME_W  = `AIU_FRAME_W
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire aiu_pkg::aiu_cfg_t  cfg,
    output logic                    oversampling_clock_out,
    input  wire logic               serial_bit_clock_in,
    output logic                    serial_bit_clock_out,
    output logic                    serial_bit_clock_oe,
    input  wire logic               serial_data_in,
    input  wire logic               word_select_in,
    output logic                    word_select_out,
    output logic                    word_select_oe,
    output logic                    sample_valid,
    input  wire logic               sample_ready,
    output aiu_pkg::aiu_sample_t    sample,
    output logic                    sample_overrun
);
    localparam int SCK_MIN = `AIU_SCK_MIN_CYC;

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [1:0]          sck_sync;
        logic [1:0]          sd_sync;
        logic [1:0]          ws_sync;
        logic                sck_d;
        logic                sck_gen;
        logic [DIV_W-1:0]    div_cnt;
        logic [FRAME_W-1:0]  bit_cnt;
        logic                ws_gen;
        logic                ws_prev;
        logic [SAMPLE_W-1:0] shift;
        logic [5:0]          nbits;
        aiu_pkg::aiu_rx_state_t rx;
        logic                pend;
        aiu_pkg::aiu_sample_t hold;
        logic                overrun;
        logic [7:0]          gap;
    } aiu_state_t;

    aiu_state_t st;
    aiu_state_t next_st;

    logic osc_rise;
    logic sck_now;
    logic sd_now;
    logic ws_now;
    logic rise;
    logic fall;
    logic samp_edge;
    logic drive_edge;
    logic buf_ready;
    logic half_done;
    logic [FRAME_W-1:0] half_len;

    // =========================================================
    // oversampling clock and output buffer
    // =========================================================
    aiu_osc_gen #(
        .PHASE_W (`AIU_PHASE_W)
    ) u_osc (
        .clk       (clk),
        .reset_n   (reset_n),
        .phase_inc (cfg.osc_phase_inc),
        .osc_out   (oversampling_clock_out),
        .osc_rise  (osc_rise)
    );

    aiu_skid #(
        .WIDTH ($bits(aiu_pkg::aiu_sample_t))
    ) u_buf (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (st.pend),
        .in_ready  (buf_ready),
        .in_data   (st.hold),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (sample)
    );

    // =========================================================
    // edge selection
    // =========================================================
    // in master mode the generated clock is used directly, no crossing
    assign sck_now = cfg.master ? st.sck_gen : st.sck_sync[1];
    assign sd_now  = st.sd_sync[1];
    assign ws_now  = cfg.master ? st.ws_gen : st.ws_sync[1];
    assign rise    = sck_now & ~st.sck_d;
    assign fall    = ~sck_now & st.sck_d;
    assign samp_edge  = cfg.clock_edge ? fall : rise;
    assign drive_edge = cfg.clock_edge ? rise : fall;
    assign half_len   = {1'b0, cfg.frame_len[FRAME_W-1:1]};
    assign half_done  = (st.bit_cnt + 1'b1 >= half_len);

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        next_st          = st;
        next_st.sck_sync = {st.sck_sync[0], serial_bit_clock_in};
        next_st.sd_sync  = {st.sd_sync[0], serial_data_in};
        next_st.ws_sync  = {st.ws_sync[0], word_select_in};
        next_st.sck_d    = sck_now;
        if (st.gap != 8'hFF) begin
            next_st.gap = st.gap + 8'h01;
        end

        // master bit clock: half period counted in oversampling edges
        if (cfg.master && osc_rise) begin
            if (st.div_cnt + 1'b1 >= cfg.sck_div) begin
                next_st.div_cnt = '0;
                next_st.sck_gen = ~st.sck_gen;
            end else begin
                next_st.div_cnt = st.div_cnt + 1'b1;
            end
        end
        if (!cfg.master) begin
            next_st.sck_gen = 1'b0;
            next_st.div_cnt = '0;
            next_st.bit_cnt = '0;
        end

        // master word select: toggles every half frame on drive edge
        if (cfg.master && drive_edge) begin
            if (half_done) begin
                next_st.bit_cnt = '0;
                next_st.ws_gen  = ~st.ws_gen;
            end else begin
                next_st.bit_cnt = st.bit_cnt + 1'b1;
            end
        end

        // receiver: a word-select change closes a word of any length
        if (samp_edge) begin
            next_st.gap = 8'h00;
            if (ws_now != st.ws_prev) begin
                if (st.rx == aiu_pkg::AIU_ST_SHIFT) begin
                    if (st.pend) begin
                        next_st.overrun = 1'b1;   // buffer full, word lost
                    end else begin
                        next_st.pend      = 1'b1;
                        next_st.hold.chan = st.ws_prev;
                        next_st.hold.data = st.shift;
                    end
                end
                next_st.rx    = aiu_pkg::AIU_ST_SHIFT;
                next_st.shift = {{(SAMPLE_W-1){1'b0}}, sd_now};
                next_st.nbits = 6'h01;
            end else if (st.nbits < 6'(SAMPLE_W)) begin
                next_st.shift = {st.shift[SAMPLE_W-2:0], sd_now};
                next_st.nbits = st.nbits + 6'h01;
            end
            next_st.ws_prev = ws_now;
        end

        // bit clock edges closer than 22 MHz allows are flagged
        if (samp_edge && st.gap < 8'(SCK_MIN - 1)) begin
            next_st.overrun = 1'b1;
        end

        if (st.pend && buf_ready) begin
            next_st.pend = 1'b0;
        end
    end

    // =========================================================
    // registers
    // =========================================================
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st         <= '0;
            st.gap     <= 8'hFF;
            st.ws_prev <= `AIU_CHAN_LEFT;
            st.rx      <= aiu_pkg::AIU_ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // pins
    // =========================================================
    // master mode drives both pins; reset leaves cfg to drive slave
    assign serial_bit_clock_out = st.sck_gen;
    assign serial_bit_clock_oe  = cfg.master;
    assign word_select_out      = st.ws_gen;
    assign word_select_oe       = cfg.master;
    assign sample_overrun       = st.overrun;
endmodule // aiu_audio_in

`default_nettype wire

/* File: verilog/aiu_regs.svh */
// constants for the audio input unit: timing, field widths, resets
`ifndef AIU_REGS_SVH
`define AIU_REGS_SVH

`define AIU_CLK_HZ          200000000
`define AIU_SCK_MAX_HZ      22000000
`define AIU_OSC_MAX_HZ      40000000
`define AIU_SCK_MIN_CYC     ((`AIU_CLK_HZ + `AIU_SCK_MAX_HZ - 1) / `AIU_SCK_MAX_HZ)
`define AIU_PHASE_W         32
`define AIU_SAMPLE_W        32
`define AIU_DIV_W           8
`define AIU_FRAME_W         8
`define AIU_RST_MASTER      1'b0
`define AIU_RST_EDGE        1'b0
`define AIU_RST_DIV         8'h04
`define AIU_RST_FRAME       8'h40
`define AIU_RST_PHASE       32'h0000_0000
`define AIU_CHAN_LEFT       1'b0

`endif

/* File: verilog/aiu_pkg.sv */
// types shared by the audio input unit
package aiu_pkg;

    // one received sample with its channel tag
    typedef struct packed {
        logic                       chan;
        logic [31:0]                data;
    } aiu_sample_t;

    // serial configuration, stands in for the serial_config_register
    typedef struct packed {
        logic                       master;
        logic                       clock_edge;
        logic [7:0]                 sck_div;
        logic [7:0]                 frame_len;
        logic [31:0]                osc_phase_inc;
    } aiu_cfg_t;

    typedef enum logic [1:0] {
        AIU_ST_IDLE = 2'b00,
        AIU_ST_SHIFT = 2'b01
    } aiu_rx_state_t;

endpackage

/* File: verilog/aiu_osc_gen.sv */
// phase accumulator that makes the oversampling clock
`timescale 1ns/1ps
`default_nettype none
`include "aiu_regs.svh"

module aiu_osc_gen #(
    parameter int PHASE_W = `AIU_PHASE_W
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [PHASE_W-1:0] phase_inc,
    output logic                    osc_out,
    output logic                    osc_rise
);
    typedef struct packed {
        logic [PHASE_W-1:0] acc;
        logic               msb_d;
    } aiu_osc_state_t;

    aiu_osc_state_t st;
    aiu_osc_state_t next_st;

    // 32-bit increment at 200 MHz gives well under one hertz of step;
    // output is the accumulator msb, so jitter is one core period
    always_comb begin
        next_st       = st;
        next_st.acc   = st.acc + phase_inc;
        next_st.msb_d = st.acc[PHASE_W-1];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign osc_out  = st.msb_d;
    assign osc_rise = st.acc[PHASE_W-1] & ~st.msb_d;
endmodule // aiu_osc_gen

`default_nettype wire

/* File: verilog/aiu_skid.sv */
// two-entry buffer between the serial receiver and the sample consumer
`timescale 1ns/1ps
`default_nettype none

module aiu_skid #(
    parameter int WIDTH = 33
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  rd;
        logic                  wr;
        logic [1:0]            count;
    } aiu_skid_state_t;

    aiu_skid_state_t st;
    aiu_skid_state_t next_st;
    logic            push;
    logic            pop;

    assign in_ready  = (st.count != 2'h2);
    assign out_valid = (st.count != 2'h0);
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers wrap at two; count is honest so full really stalls
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = ~st.wr;
        end
        if (pop) begin
            next_st.rd = ~st.rd;
        end
        case ({push, pop})
            2'b10:   next_st.count = st.count + 2'h1;
            2'b01:   next_st.count = st.count - 2'h1;
            default: next_st.count = st.count;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // aiu_skid

`default_nettype wire

/* File: tb/aiu_audio_in_properties.sv */
// port assertions of the audio input unit
`timescale 1ns/1ps
`default_nettype none
module aiu_audio_in_chk (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire aiu_pkg::aiu_cfg_t    cfg,
    input wire logic                 oversampling_clock_out,
    input wire logic                 serial_bit_clock_out,
    input wire logic                 serial_bit_clock_oe,
    input wire logic                 word_select_out,
    input wire logic                 word_select_oe,
    input wire logic                 sample_valid,
    input wire logic                 sample_ready,
    input wire aiu_pkg::aiu_sample_t sample,
    input wire logic                 sample_overrun
);
    // ==================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a word offered but not yet taken
    sequence s_stall;
        sample_valid && !sample_ready;
    endsequence
    sequence s_ws_move;
        cfg.master && $changed(word_select_out);
    endsequence
    // the edge opposite to the sampling edge; word select is registered
    // off that edge, so the clock moved one cycle before word select does
    sequence s_drive_edge;
        $past(serial_bit_clock_out) != $past(serial_bit_clock_out, 2) &&
        $past(serial_bit_clock_out) == cfg.clock_edge;
    endsequence
    chk_sck_dir: assert property (serial_bit_clock_oe == cfg.master)
        else $error("bit clock direction wrong");
    chk_ws_dir: assert property (word_select_oe == cfg.master)
        else $error("word select direction wrong");
    // 22 MHz at 200 MHz core means at least 10 cycles between rises
    chk_sck_rate: assert property ($rose(serial_bit_clock_out) |=>
        !$rose(serial_bit_clock_out) [*8] ##1 !$rose(serial_bit_clock_out))
        else $error("bit clock too fast");
    chk_osc_rate: assert property ($rose(oversampling_clock_out) |=>
        !$rose(oversampling_clock_out) [*4])
        else $error("oversampling clock too fast");
    chk_ws_edge: assert property (s_ws_move |-> s_drive_edge)
        else $error("word select moved on the sampling edge");
    chk_valid_hold: assert property (s_stall |=> sample_valid)
        else $error("offered word withdrawn");
    chk_data_hold: assert property (s_stall |=> $stable(sample))
        else $error("offered word changed");
    chk_overrun_kept: assert property (sample_overrun |=> sample_overrun)
        else $error("overrun flag dropped");
endmodule // aiu_audio_in_chk
bind aiu_audio_in aiu_audio_in_chk u_chk (.clk, .reset_n, .cfg,
    .oversampling_clock_out, .serial_bit_clock_out, .serial_bit_clock_oe,
    .word_select_out, .word_select_oe, .sample_valid, .sample_ready,
    .sample, .sample_overrun);
`default_nettype wire

/* File: tb/aiu_adc_model.sv */
// behavioural converter on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module aiu_adc_model (
    output logic      sck,
    output logic      ws,
    output logic      sd,
    input  wire logic dev_sck,
    input  wire logic dev_ws,
    input  wire logic master,
    input  wire logic edge_sel
);
    // ==================
    // slave timing: 62 ns bit period, under 22 MHz and unrelated to core
    time half = 31ns;
    initial begin
        sck = 1'b0;
        ws = 1'b0;
        sd = 1'b0;
    end
    // one word msb first; ws and data move on the drive edge
    task automatic word(input logic ch, input logic [31:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            sck = edge_sel;
            ws = ch;
            sd = d[i];
            #half;
            sck = ~edge_sel;
            #half;
        end
        sck = edge_sel;
        sd = ~sd; // released line shows no stale bit
    endtask
    // master timing: data follows the device word select once it has moved,
    // so every bit of a word carries that word's channel level
    always @(dev_ws) begin
        if (master) begin
            sd = dev_ws;
        end
    end
endmodule // aiu_adc_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the audio input unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic                 clk;
    logic                 reset_n;
    logic                 sample_ready;
    aiu_pkg::aiu_cfg_t    cfg;
    aiu_pkg::aiu_sample_t sample;
    logic                 oversampling_clock_out;
    logic                 serial_bit_clock_out;
    logic                 serial_bit_clock_oe;
    logic                 word_select_out;
    logic                 word_select_oe;
    logic                 sample_valid;
    logic                 sample_overrun;
    logic                 m_sck;
    logic                 m_ws;
    wire logic            serial_data_in;
    int                   checks = 0;
    int                   miscompares = 0;
    // pin level: whoever holds the enable drives the wire
    wire logic serial_bit_clock_in = serial_bit_clock_oe ?
                                     serial_bit_clock_out : m_sck;
    wire logic word_select_in = word_select_oe ? word_select_out : m_ws;
    aiu_audio_in dut (.clk, .reset_n, .cfg, .oversampling_clock_out,
        .serial_bit_clock_in, .serial_bit_clock_out, .serial_bit_clock_oe,
        .serial_data_in, .word_select_in, .word_select_out, .word_select_oe,
        .sample_valid, .sample_ready, .sample, .sample_overrun);
    aiu_adc_model adc (.sck(m_sck), .ws(m_ws), .sd(serial_data_in),
        .dev_sck(serial_bit_clock_out), .dev_ws(word_select_out),
        .master(cfg.master), .edge_sel(cfg.clock_edge));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==================
    // shared tasks
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset(input logic m, input logic e);
        reset_n = 1'b0;
        cfg.master = m;
        cfg.clock_edge = e;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
    endtask
    // wait for a word, judge it, then take it in one cycle
    task automatic take(input logic ch, input logic [31:0] d);
        int n;
        n = 0;
        while (sample_valid !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 4000) begin
            miscompares++;
            tally_and_finish();
        end
        `CHK("chan", ch, sample.chan)
        `CHK("data", d, sample.data)
        sample_ready = 1'b1;
        @(posedge clk);
        #1 sample_ready = 1'b0;
    endtask
    // core cycles until word select next moves
    task automatic ws_gap(output int n);
        logic w;
        w = word_select_out;
        n = 0;
        while (word_select_out === w && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    // ==================
    // scenarios
    task automatic t_slave(input logic e);
        do_reset(1'b0, e);
        `CHK("sck_oe", 1'b0, serial_bit_clock_oe)
        `CHK("ws_oe", 1'b0, word_select_oe)
        adc.word(1'b0, 32'h5, 3); // no select change yet: partial, dropped
        adc.word(1'b1, 32'h0000_A5C3, 16);
        adc.word(1'b0, 32'h00F0_0F5A, 24);
        adc.word(1'b1, 32'h0, 1); // closes the long word
        take(1'b1, 32'h0000_A5C3);
        take(1'b0, 32'h00F0_0F5A);
        $display("test slave edge %0d done", e);
    endtask
    task automatic t_stall();
        do_reset(1'b0, 1'b0);
        // two words fill the buffer, one waits, the fourth is lost
        adc.word(1'b0, 32'h1, 2);
        adc.word(1'b1, 32'h11, 8);
        adc.word(1'b0, 32'h22, 8);
        adc.word(1'b1, 32'h33, 8);
        adc.word(1'b0, 32'h44, 8);
        adc.word(1'b1, 32'h0, 1);
        repeat (8) @(posedge clk);
        #1 `CHK("overrun", 1'b1, sample_overrun)
        take(1'b1, 32'h11);
        take(1'b0, 32'h22);
        take(1'b1, 32'h33);
        `CHK("drained", 1'b0, sample_valid)
        $display("test stall done");
    endtask
    task automatic t_master();
        int n;
        do_reset(1'b1, 1'b0);
        `CHK("sck_oe", 1'b1, serial_bit_clock_oe)
        `CHK("ws_oe", 1'b1, word_select_oe)
        take(1'b1, 32'hFF);
        take(1'b0, 32'h0);
        ws_gap(n);
        ws_gap(n);
        // half frame of bits, two divided halves, osc period in cycles
        `CHK("ws_gap", 8 * 2 * 2 * 8, n)
        $display("test master done");
    endtask
    initial begin
        reset_n = 1'b0;
        sample_ready = 1'b0;
        cfg = '{master: 1'b0, clock_edge: 1'b0, sck_div: 8'h02,
                frame_len: 8'h10, osc_phase_inc: 32'h2000_0000};
        t_slave(1'b0);
        t_slave(1'b1);
        t_stall();
        t_master();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
